// ---- hw/lcg_gate4_select.sv ----
// Fourth-gate input selection stage with its select register
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - With the data-4 inverted enable set, inverted data 4 feeds gate 4.
// - With the data-4 inverted enable clear, inverted data 4 is kept out.
// - Bit 2 set lets inverted data 2 into gate 4, clear keeps it out.
// - Bit 1 set lets true data 1 into gate 4, clear keeps it out.

module lcg_gate4_select
    import lcg_pkg::*;
(
    input wire logic clk, // System clock, 10 MHz
    input wire logic reset, // Synchronous reset, active high
    input wire lcg_bus_req_type bus_req, // Register port request
    output logic [LCG_DATA_W-1:0] rd_data, // Read data, cycle after read
    input wire logic [LCG_NUM_INPUTS-1:0] data_in, // Data inputs 1 to 4
    output logic [LCG_DATA_W-1:0] gate4_input_select, // Select register
    output logic [LCG_DATA_W-1:0] gated_terms, // Terms now entering gate 4
    output logic fourth_gate_signal // OR of the gated terms
);

    // ------------------------------------------------------------------
    // Term selection
    // ------------------------------------------------------------------
    // Terms are laid out like the select register, so bit n of the
    // result is the term enabled by bit n of the select value.
    function automatic logic [LCG_DATA_W-1:0] gate_terms(
        input logic [LCG_DATA_W-1:0] sel,
        input logic [LCG_NUM_INPUTS-1:0] d
    );
        logic [LCG_DATA_W-1:0] t;
        t = LCG_ZERO_BYTE;
        t[LCG_D4_TRUE_BIT] = sel[LCG_D4_TRUE_BIT] & d[3];
        t[LCG_D4_INV_BIT] = sel[LCG_D4_INV_BIT] & ~d[3];
        t[LCG_D3_TRUE_BIT] = sel[LCG_D3_TRUE_BIT] & d[2];
        t[LCG_D3_INV_BIT] = sel[LCG_D3_INV_BIT] & ~d[2];
        t[LCG_D2_TRUE_BIT] = sel[LCG_D2_TRUE_BIT] & d[1];
        t[LCG_D2_INV_BIT] = sel[LCG_D2_INV_BIT] & ~d[1];
        t[LCG_D1_TRUE_BIT] = sel[LCG_D1_TRUE_BIT] & d[0];
        t[LCG_D1_INV_BIT] = sel[LCG_D1_INV_BIT] & ~d[0];
        return t;
    endfunction : gate_terms

    function automatic logic addr_hit(
        input logic [LCG_ADDR_W-1:0] a,
        input logic [LCG_ADDR_W-1:0] offs
    );
        return a == offs;
    endfunction : addr_hit

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    lcg_select_type sel_r;
    logic [LCG_DATA_W-1:0] terms_r;
    logic [LCG_DATA_W-1:0] terms_nxt;
    logic gate_r;
    logic [LCG_DATA_W-1:0] rd_data_r;
    logic [LCG_DATA_W-1:0] rd_data_nxt;

    // ------------------------------------------------------------------
    // Select register
    // ------------------------------------------------------------------
    // The cell leaves this register undefined at reset; clearing it
    // keeps gate 4 quiet until software has set it up.
    always_ff @(posedge clk) begin
        if (reset) begin
            sel_r <= LCG_SEL_RESET;
        end else if (bus_req.wr && addr_hit(bus_req.addr, LCG_SEL_OFFSET)) begin
            sel_r <= bus_req.wdata;
        end
    end

    // ------------------------------------------------------------------
    // Gate 4 input stage
    // ------------------------------------------------------------------
    // Registered so every output leaves a flip-flop; costs one cycle
    // of latency from data_in and from a select write.
    always_comb begin
        terms_nxt = gate_terms(sel_r, data_in);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            terms_r <= LCG_ZERO_BYTE;
            gate_r <= 1'b0;
        end else begin
            terms_r <= terms_nxt;
            gate_r <= |terms_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    // Unmapped reads and idle cycles return zero.
    always_comb begin
        rd_data_nxt = LCG_ZERO_BYTE;
        if (bus_req.rd) begin
            if (addr_hit(bus_req.addr, LCG_SEL_OFFSET)) begin
                rd_data_nxt = sel_r;
            end else if (addr_hit(bus_req.addr, LCG_TERMS_OFFSET)) begin
                rd_data_nxt = terms_r;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rd_data_r <= LCG_ZERO_BYTE;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data = rd_data_r;
    assign gate4_input_select = sel_r;
    assign gated_terms = terms_r;
    assign fourth_gate_signal = gate_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    property p_d4_inv_in;
        gate4_input_select[LCG_D4_INV_BIT] && !data_in[3]
            |=> gated_terms[LCG_D4_INV_BIT] && fourth_gate_signal;
    endproperty
    a_d4_inv_in: assert property (p_d4_inv_in)
        else $error("inverted data 4 not gated into gate 4");

    property p_d4_inv_out;
        !gate4_input_select[LCG_D4_INV_BIT] |=> !gated_terms[LCG_D4_INV_BIT];
    endproperty
    a_d4_inv_out: assert property (p_d4_inv_out)
        else $error("inverted data 4 leaked into gate 4");

    property p_d2_inv;
        !$past(reset) |-> gated_terms[LCG_D2_INV_BIT] ==
            ($past(gate4_input_select[LCG_D2_INV_BIT]) && !$past(data_in[1]));
    endproperty
    a_d2_inv: assert property (p_d2_inv)
        else $error("inverted data 2 term wrong");

    property p_d1_true;
        !$past(reset) |-> gated_terms[LCG_D1_TRUE_BIT] ==
            ($past(gate4_input_select[LCG_D1_TRUE_BIT]) && $past(data_in[0]));
    endproperty
    a_d1_true: assert property (p_d1_true)
        else $error("true data 1 term wrong");

    property p_other_terms;
        !$past(reset) |-> gated_terms ==
            gate_terms($past(gate4_input_select), $past(data_in));
    endproperty
    a_other_terms: assert property (p_other_terms)
        else $error("gate 4 term vector wrong");

    property p_gate_or;
        fourth_gate_signal == (|gated_terms);
    endproperty
    a_gate_or: assert property (p_gate_or)
        else $error("gate 4 output is not the OR of its terms");

    property p_all_clear_quiet;
        gate4_input_select == LCG_ZERO_BYTE [*2] |-> !fourth_gate_signal;
    endproperty
    a_all_clear_quiet: assert property (p_all_clear_quiet)
        else $error("gate 4 active with no input enabled");

    property p_write_then_read;
        bus_req.wr && bus_req.addr == LCG_SEL_OFFSET ##1
            bus_req.rd && bus_req.addr == LCG_SEL_OFFSET && !bus_req.wr
            |=> rd_data == $past(bus_req.wdata, 2);
    endproperty
    a_write_then_read: assert property (p_write_then_read)
        else $error("select register readback mismatch");

    property p_read_idle_zero;
        !bus_req.rd |=> rd_data == LCG_ZERO_BYTE;
    endproperty
    a_read_idle_zero: assert property (p_read_idle_zero)
        else $error("read data present without a read");

    c_d4_inv_gate: cover property (
        gate4_input_select[LCG_D4_INV_BIT] && !data_in[3] ##1
        fourth_gate_signal);
    c_d2_inv_gate: cover property (gated_terms[LCG_D2_INV_BIT]);
    c_d1_true_gate: cover property (gated_terms[LCG_D1_TRUE_BIT]);
    c_sel_readback: cover property (
        bus_req.rd && bus_req.addr == LCG_SEL_OFFSET ##1
        rd_data != LCG_ZERO_BYTE);

endmodule : lcg_gate4_select

`default_nettype wire

// ---- hw/lcg_pkg.sv ----
// Package for the fourth-gate input selection stage of a logic cell
package lcg_pkg;

    // ------------------------------------------------------------------
    // Register port geometry
    // ------------------------------------------------------------------
    localparam int LCG_ADDR_W = 4;
    localparam int LCG_DATA_W = 8;
    localparam int LCG_NUM_INPUTS = 4;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [LCG_ADDR_W-1:0] LCG_SEL_OFFSET = 4'h0;
    localparam logic [LCG_ADDR_W-1:0] LCG_TERMS_OFFSET = 4'h1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [LCG_DATA_W-1:0] LCG_SEL_RESET = 8'h00;
    localparam logic [LCG_DATA_W-1:0] LCG_ZERO_BYTE = 8'h00;

    // ------------------------------------------------------------------
    // Field positions in gate4_input_select
    // ------------------------------------------------------------------
    localparam int LCG_D4_TRUE_BIT = 7;
    localparam int LCG_D4_INV_BIT = 6;
    localparam int LCG_D3_TRUE_BIT = 5;
    localparam int LCG_D3_INV_BIT = 4;
    localparam int LCG_D2_TRUE_BIT = 3;
    localparam int LCG_D2_INV_BIT = 2;
    localparam int LCG_D1_TRUE_BIT = 1;
    localparam int LCG_D1_INV_BIT = 0;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [LCG_ADDR_W-1:0] addr;
        logic [LCG_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } lcg_bus_req_type;

    typedef struct packed {
        logic g4_data4_true_enable;
        logic g4_data4_inverted_enable;
        logic g4_data3_true_enable;
        logic g4_data3_inverted_enable;
        logic g4_data2_true_enable;
        logic g4_data2_inverted_enable;
        logic g4_data1_true_enable;
        logic g4_data1_inverted_enable;
    } lcg_select_type;

endpackage : lcg_pkg

// ---- testbench/test_logic_cell_gate4_input_select.sv ----
// Self-checking bench for the fourth-gate input selection stage
`timescale 1ns/1ps
`default_nettype none

module test_logic_cell_gate4_input_select;
    import lcg_pkg::*;

    logic clk;
    logic reset;
    lcg_bus_req_type bus_req;
    logic [3:0] data_in;
    logic [7:0] rd_data;
    logic [7:0] gate4_input_select;
    logic [7:0] gated_terms;
    logic fourth_gate_signal;
    int n_fail = 0;
    int tests_run = 0;

    lcg_gate4_select u_lcg_gate4_select (
        .clk(clk),
        .reset(reset),
        .bus_req(bus_req),
        .rd_data(rd_data),
        .data_in(data_in),
        .gate4_input_select(gate4_input_select),
        .gated_terms(gated_terms),
        .fourth_gate_signal(fourth_gate_signal)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] terms_of(input logic [3:0] d);
        return {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]};
    endfunction : terms_of

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Leaves the strobe up, so a read or idle must follow at the next edge
    task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
    endtask : bus_write

    task automatic bus_idle();
        bus_req <= '0;
        @(posedge clk);
    endtask : bus_idle

    task automatic bus_read(input logic [3:0] a, input logic [7:0] exp);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req <= '0;
        @(negedge clk);
        check("rd_data", exp, rd_data);
        @(posedge clk);
        @(negedge clk);
        check("rd_data after", 8'h00, rd_data);
        @(posedge clk);
    endtask : bus_read

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_gate_table();
        logic [7:0] sels [11];
        logic [7:0] exp;
        sels = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80,
                 8'hFF, 8'h00, 8'hBF};
        foreach (sels[i]) begin
            bus_write(LCG_SEL_OFFSET, sels[i]);
            bus_idle();
            for (int d = 0; d < 16; d++) begin
                data_in <= d[3:0];
                @(posedge clk);
                @(posedge clk);
                @(negedge clk);
                exp = sels[i] & terms_of(d[3:0]);
                check("gated_terms", exp, gated_terms);
                check("gate", {7'h00, |exp}, {7'h00, fourth_gate_signal});
                @(posedge clk);
            end
        end
    endtask : test_gate_table

    task automatic test_registers();
        bus_write(LCG_SEL_OFFSET, 8'hA5);
        bus_read(LCG_SEL_OFFSET, 8'hA5);
        bus_write(LCG_TERMS_OFFSET, 8'h5A);
        bus_read(LCG_SEL_OFFSET, 8'hA5);
        bus_read(4'hF, 8'h00);
        data_in <= 4'h9;
        @(posedge clk);
        @(posedge clk);
        bus_read(LCG_TERMS_OFFSET, 8'hA5 & terms_of(4'h9));
        check("select", 8'hA5, gate4_input_select);
    endtask : test_registers

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end

    initial begin
        reset = 1'b1;
        bus_req = '0;
        data_in = 4'h0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        check("reset select", LCG_SEL_RESET, gate4_input_select);
        check("reset terms", 8'h00, gated_terms);
        @(posedge clk);
        reset <= 1'b0;
        test_gate_table();
        test_registers();
        report_and_stop();
    end

endmodule : test_logic_cell_gate4_input_select

`default_nettype wire
